// ===== pbcmd_primary.sv
// Purpose: Primary command register and the gating it applies
// Assumes: Config accesses and event inputs come from core_clk logic;
//   mode straps come from pins
// Notes: Read data returns one cycle after the read strobe
// What this block does
// RULE1 - Bit 0 clear ignores primary I/O; set lets the bridge claim them.
// RULE2 - Bit 1 clear ignores primary memory; set lets the bridge claim them.
// RULE3 - Bit 2 clear: no primary mastering, no secondary memory/I/O response.
// RULE4 - Bit 2 set: master primary memory/I/O forwarded from secondary.
// RULE5 - Reverse bridge on PCI-X may issue split completions regardless.
// RULE6 - Bit 3 reads zero; special cycles are never claimed.
// RULE7 - Bit 4 reads zero; write-invalidate only when forwarded, not PCI-X.
// RULE8 - Bit 5 reads zero; palette snoops on primary are ignored.
// RULE9 - Bit 6 set: parity error or poisoned TLP sets the detected flag.
// RULE10 - Bit 6 clear: parity errors are ignored, traffic carries on.
// RULE11 - Bit 7 reads zero, wait cycle control absent.
// RULE12 - Forward mode sends error messages only while bit 8 set.
// RULE13 - Reverse mode drives the system error pin only while bit 8 set.
// RULE14 - Bit 9 reads zero, fast back-to-back absent.
// RULE15 - Bit 10 set blocks and releases INTx; clear allows INTx.
// RULE16 - Status bit 24 is write-one-to-clear, set only with bit 6 set.
// RULE17 - Writable bits reset to zero; bits 15 to 11 read zero.
`timescale 1ns/10ps
module pbcmd_primary
  import pbcmd_pkg::*;
#(
  parameter int ADDR_W = PBCMD_ADDR_W
)
(
  input wire logic core_clk,
  input wire logic reset,
  input wire logic cfg_wr,
  input wire logic cfg_rd,
  input wire logic [ADDR_W-1:0] cfg_addr,
  input wire logic [3:0] cfg_be,
  input wire logic [31:0] cfg_wdata,
  output logic [31:0] cfg_rdata,
  output logic cfg_rvalid,
  input wire logic reverse_strap,
  input wire logic pcix_strap,
  input wire logic pri_io_hit,
  input wire logic pri_mem_hit,
  input wire logic fwd_req,
  input wire logic fwd_mwi,
  input wire logic split_cmpl_req,
  input wire logic sec_hit,
  input wire logic parity_event,
  input wire logic err_event,
  input wire logic intx_req,
  output logic pri_io_claim,
  output logic pri_mem_claim,
  output logic pri_master_req,
  output logic pri_mwi_cmd,
  output logic pri_split_req,
  output logic sec_claim,
  output logic err_msg_send,
  output logic serr_out,
  output logic serr_oe,
  output logic intx_assert
);

  logic [15:0] cmd;
  logic [15:0] next_cmd;
  logic [1:0] strap_sync;
  logic reverse_mode;
  logic pcix_mode;
  logic mdpe;
  logic [31:0] next_rdata;

  // Decode
  wire cmd_hit = (cfg_addr == PBCMD_CMD_OFFSET[ADDR_W-1:0]);
  wire wr_hit = cfg_wr & cmd_hit;
  wire rd_hit = cfg_rd & cmd_hit;
  wire [15:0] lane_mask = {{8{cfg_be[1]}}, {8{cfg_be[0]}}};
  wire [15:0] wr_mask = PBCMD_CMD_WMASK & lane_mask & {16{wr_hit}};

  wire io_en = cmd[PBCMD_IO_BIT];
  wire mem_en = cmd[PBCMD_MEM_BIT];
  wire bme = cmd[PBCMD_BME_BIT];
  wire per_en = cmd[PBCMD_PER_BIT];
  wire serr_en = cmd[PBCMD_SERR_BIT];
  wire intx_dis = cmd[PBCMD_INTD_BIT];

  // Only writable bits ever change; the rest hold reset zero
  assign next_cmd = (cmd & ~wr_mask) | (cfg_wdata[15:0] & wr_mask); // [RULE17]

  wire mdpe_set = parity_event & per_en; // [RULE9] [RULE10] [RULE16]
  wire mdpe_clr = wr_hit & cfg_be[3] & cfg_wdata[PBCMD_MDPE_BIT]; // [RULE16]

  // Read view: hard-wired zero bits masked out
  wire [15:0] cmd_view = cmd & PBCMD_CMD_WMASK; // [RULE6] [RULE7] [RULE8]
  wire [31:0] status_view = {7'h00, mdpe, 8'h00, cmd_view}; // [RULE11]
  assign next_rdata = rd_hit ? status_view : 32'h0000_0000; // [RULE14]

  // Transaction gating
  wire next_io_claim = pri_io_hit & io_en; // [RULE1]
  wire next_mem_claim = pri_mem_hit & mem_en; // [RULE2]
  wire next_master = fwd_req & bme; // [RULE3] [RULE4]
  wire next_sec = sec_hit & bme; // [RULE3]
  // Write-invalidate passes only with a forwarded request, never on PCI-X
  wire next_mwi = fwd_req & fwd_mwi & bme & ~pcix_mode; // [RULE7]
  wire split_ok = reverse_mode & pcix_mode; // [RULE5]
  wire next_split = split_cmpl_req & (split_ok | bme); // [RULE5]
  wire next_msg = err_event & serr_en & ~reverse_mode; // [RULE12]
  wire next_serr = err_event & serr_en & reverse_mode; // [RULE13]
  wire next_intx = intx_req & ~intx_dis; // [RULE15]

  pbcmd_sync #(
    .WIDTH(2)
  ) u_strap_sync (
    .core_clk(core_clk),
    .reset(reset),
    .pin_level({pcix_strap, reverse_strap}),
    .sync_level(strap_sync)
  );

  assign reverse_mode = strap_sync[0];
  assign pcix_mode = strap_sync[1];

  pbcmd_flag u_mdpe (
    .core_clk(core_clk),
    .reset(reset),
    .set_evt(mdpe_set),
    .clr_evt(mdpe_clr),
    .flag(mdpe)
  );

  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      cmd <= PBCMD_CMD_RESET; // [RULE17]
      cfg_rdata <= 32'h0000_0000;
      cfg_rvalid <= 1'b0;
    end
    else
    begin
      cmd <= next_cmd;
      cfg_rdata <= next_rdata;
      cfg_rvalid <= cfg_rd;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      pri_io_claim <= 1'b0;
      pri_mem_claim <= 1'b0;
      pri_master_req <= 1'b0;
      pri_mwi_cmd <= 1'b0;
      pri_split_req <= 1'b0;
      sec_claim <= 1'b0;
    end
    else
    begin
      pri_io_claim <= next_io_claim;
      pri_mem_claim <= next_mem_claim;
      pri_master_req <= next_master;
      pri_mwi_cmd <= next_mwi;
      pri_split_req <= next_split;
      sec_claim <= next_sec;
    end
  end

  // Open-drain system error pin: drive low while enabled
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      err_msg_send <= 1'b0;
      serr_out <= 1'b1;
      serr_oe <= 1'b0;
      intx_assert <= 1'b0;
    end
    else
    begin
      err_msg_send <= next_msg;
      serr_out <= ~next_serr;
      serr_oe <= next_serr;
      intx_assert <= next_intx;
    end
  end

  default clocking cb @(posedge core_clk);
  endclocking

  default disable iff (reset);

  AST_IO_FOLLOW: assert property ( // [RULE1]
    pri_io_hit |=> (pri_io_claim == $past(io_en)))
    else $error("io claim does not follow io enable");

  AST_IO_CAUSE: assert property ( // [RULE1]
    pri_io_claim |-> $past(io_en) && $past(pri_io_hit))
    else $error("io claimed without enable and hit");

  AST_MEM_FOLLOW: assert property ( // [RULE2]
    pri_mem_hit |=> (pri_mem_claim == $past(mem_en)))
    else $error("memory claim does not follow memory enable");

  AST_MEM_CAUSE: assert property ( // [RULE2]
    pri_mem_claim |-> $past(mem_en) && $past(pri_mem_hit))
    else $error("memory claimed without enable and hit");

  AST_SEC_FOLLOW: assert property ( // [RULE3]
    sec_hit |=> (sec_claim == $past(bme)))
    else $error("secondary claim does not follow master enable");

  AST_MASTER_OFF: assert property ( // [RULE3]
    (pri_master_req || sec_claim) |-> $past(bme))
    else $error("mastering or secondary claim with master off");

  AST_MASTER_ON: assert property ( // [RULE4]
    (fwd_req && bme) |=> pri_master_req)
    else $error("forwarded request not mastered");

  AST_MASTER_CAUSE: assert property ( // [RULE4]
    pri_master_req |-> $past(fwd_req))
    else $error("primary mastering without forwarded request");

  AST_SPLIT: assert property ( // [RULE5]
    (split_cmpl_req && reverse_mode && pcix_mode) |=> pri_split_req)
    else $error("split completion blocked in PCI-X reverse mode");

  AST_SPLIT_BME: assert property ( // [RULE5]
    (split_cmpl_req && bme) |=> pri_split_req)
    else $error("split completion blocked with master on");

  AST_SPLIT_OFF: assert property ( // [RULE3] [RULE5]
    pri_split_req |-> $past(split_cmpl_req) && ($past(bme)
      || ($past(reverse_mode) && $past(pcix_mode))))
    else $error("split completion issued while not allowed");

  AST_RO_ZERO: assert property ( // [RULE6] [RULE7] [RULE8] [RULE11] [RULE14]
    cfg_rvalid |-> (cfg_rdata[9] == 1'b0) && (cfg_rdata[7] == 1'b0)
      && (cfg_rdata[5:3] == 3'h0))
    else $error("hard-wired command bit read as one");

  AST_RSVD_ZERO: assert property ( // [RULE17]
    cfg_rvalid |-> (cfg_rdata[15:11] == 5'h00))
    else $error("reserved command bits read as one");

  AST_CMD_WRITE: assert property ( // [RULE17]
    (wr_hit && cfg_be[0]) |=> (cmd[7:0]
      == ($past(cfg_wdata[7:0]) & PBCMD_CMD_WMASK[7:0])))
    else $error("low command byte write did not land");

  AST_READ_BACK: assert property ( // [RULE17]
    rd_hit |=> (cfg_rdata[15:0] == ($past(cmd) & PBCMD_CMD_WMASK)))
    else $error("command read data differs from register");

  AST_MDPE_READ: assert property ( // [RULE16]
    rd_hit |=> (cfg_rdata[PBCMD_MDPE_BIT] == $past(mdpe)))
    else $error("detected flag read data differs from flag");

  AST_MWI: assert property ( // [RULE7]
    pri_mwi_cmd |-> $past(fwd_req) && $past(fwd_mwi) && !$past(pcix_mode))
    else $error("write-invalidate issued without forwarding");

  AST_MWI_PCIX: assert property ( // [RULE7]
    pcix_mode |=> !pri_mwi_cmd)
    else $error("write-invalidate issued in PCI-X mode");

  AST_MDPE_SET: assert property ( // [RULE9]
    (parity_event && per_en) |=> mdpe)
    else $error("parity error did not set detected flag");

  AST_MDPE_GATE: assert property ( // [RULE10] [RULE16]
    $rose(mdpe) |-> $past(per_en) && $past(parity_event))
    else $error("detected flag set without parity response enable");

  AST_MDPE_CLR: assert property ( // [RULE16]
    (mdpe && mdpe_clr && !mdpe_set) |=> !mdpe)
    else $error("write one did not clear detected flag");

  AST_ERR_MSG: assert property ( // [RULE12]
    err_msg_send |-> $past(serr_en) && !$past(reverse_mode))
    else $error("error message sent while disabled");

  AST_ERR_MSG_ON: assert property ( // [RULE12]
    (err_event && serr_en && !reverse_mode) |=> err_msg_send)
    else $error("enabled error message not sent");

  AST_SERR_PIN: assert property ( // [RULE13]
    serr_oe |-> !serr_out && $past(serr_en) && $past(reverse_mode))
    else $error("system error pin driven while disabled");

  AST_SERR_ON: assert property ( // [RULE13]
    (err_event && serr_en && reverse_mode) |=> serr_oe && !serr_out)
    else $error("enabled system error pin not driven");

  AST_SERR_IDLE: assert property ( // [RULE13]
    !serr_oe |-> serr_out)
    else $error("system error pin value low while released");

  AST_INTX: assert property ( // [RULE15]
    intx_dis |=> !intx_assert)
    else $error("INTx asserted while disabled");

  AST_INTX_ON: assert property ( // [RULE15]
    (intx_req && !intx_dis) |=> intx_assert)
    else $error("allowed INTx not asserted");

  AST_RESET_ZERO: assert property ( // [RULE17]
    @(posedge core_clk) disable iff (1'b0)
    reset |=> (cmd == 16'h0000) && !intx_assert && !serr_oe)
    else $error("command bits not zero after reset");

endmodule // pbcmd_primary

// ===== pbcmd_pkg.sv
// Purpose: Shared constants for the primary command register block
// Assumes: Configuration space addressed by byte, one 32-bit word each
// Notes: Status half of the word holds only the parity-detected flag
package pbcmd_pkg;

  localparam int PBCMD_ADDR_W = 12;
  localparam logic [11:0] PBCMD_CMD_OFFSET = 12'h004;

  localparam int PBCMD_IO_BIT = 0;
  localparam int PBCMD_MEM_BIT = 1;
  localparam int PBCMD_BME_BIT = 2;
  localparam int PBCMD_SPC_BIT = 3;
  localparam int PBCMD_MWI_BIT = 4;
  localparam int PBCMD_VGA_BIT = 5;
  localparam int PBCMD_PER_BIT = 6;
  localparam int PBCMD_WAIT_BIT = 7;
  localparam int PBCMD_SERR_BIT = 8;
  localparam int PBCMD_FBB_BIT = 9;
  localparam int PBCMD_INTD_BIT = 10;
  localparam int PBCMD_MDPE_BIT = 24;

  // Writable command bits: 0, 1, 2, 6, 8, 10
  localparam logic [15:0] PBCMD_CMD_WMASK = 16'h0547;
  localparam logic [15:0] PBCMD_CMD_RESET = 16'h0000;
  localparam logic PBCMD_MDPE_RESET = 1'b0;

  localparam int PBCMD_SYNC_STAGES = 2;

endpackage : pbcmd_pkg

// ===== pbcmd_sync.sv
// Purpose: Two-flop synchroniser for static mode straps
// Assumes: Inputs are levels from pins, not pulses
// Notes: First stage is read only by the second stage
`timescale 1ns/10ps
module pbcmd_sync
  import pbcmd_pkg::*;
#(
  parameter int WIDTH = 2
)
(
  input wire logic core_clk,
  input wire logic reset,
  input wire logic [WIDTH-1:0] pin_level,
  output logic [WIDTH-1:0] sync_level
);

  genvar gi;
  generate
    for (gi = 0; gi < WIDTH; gi++)
    begin : g_bit
      logic stage1;
      logic stage2;
      always_ff @(posedge core_clk)
      begin
        if (reset)
        begin
          stage1 <= 1'b0;
          stage2 <= 1'b0;
        end
        else
        begin
          stage1 <= pin_level[gi];
          stage2 <= stage1;
        end
      end
      assign sync_level[gi] = stage2;
    end
  endgenerate

endmodule // pbcmd_sync

// ===== pbcmd_flag.sv
// Purpose: Sticky status flag, hardware set, write-one-to-clear
// Assumes: Set and clear are single-cycle strobes on core_clk
// Notes: A set in the clearing cycle wins, so no event is lost
`timescale 1ns/10ps
module pbcmd_flag
  import pbcmd_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset,
  input wire logic set_evt,
  input wire logic clr_evt,
  output logic flag
);

  logic next_flag;

  assign next_flag = set_evt | (flag & ~clr_evt);

  always_ff @(posedge core_clk)
  begin
    if (reset)
      flag <= PBCMD_MDPE_RESET;
    else
      flag <= next_flag;
  end

endmodule // pbcmd_flag

// ===== pbcmd_host_model.sv
// Purpose: Far-side traffic source for the primary command block
// Assumes: Drives on the falling edge, bridge samples on the rising
// Notes: System error line has a pull-up, high whenever released
`timescale 1ns/10ps
module pbcmd_host_model
  import pbcmd_pkg::*;
(
  input wire logic core_clk,
  input wire logic run,
  input wire logic serr_out,
  input wire logic serr_oe,
  output logic [8:0] evt,
  output logic serr_line
);
  assign serr_line = serr_oe ? serr_out : 1'b1;
  // Random hits, requests and error events while traffic runs
  always @(negedge core_clk)
  begin
    evt <= run ? 9'($urandom()) : 9'h000;
  end
endmodule // pbcmd_host_model

// ===== bridge_primary_command_register_bench.sv
// Purpose: Self-checking bench for the primary command register
// Assumes: Events 0 io,1 mem,2 fwd,3 mwi,4 split,5 sec,6 par,7 err,8 intx
// Notes: Outputs are checked one cycle after the events that cause them
`timescale 1ns/10ps
module bridge_primary_command_register_bench
  import pbcmd_pkg::*;
();
  localparam logic [15:0] RW_BITS = 16'h0547;
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic cfg_wr = 1'b0;
  logic cfg_rd = 1'b0;
  logic [11:0] cfg_addr = 12'h000;
  logic [3:0] cfg_be = 4'h0;
  logic [31:0] cfg_wdata = 32'h0000_0000;
  logic [31:0] cfg_rdata;
  logic cfg_rvalid;
  logic [1:0] strap = 2'h0;
  logic run = 1'b0;
  logic run_q = 1'b0;
  logic [8:0] evt;
  wire logic [9:0] outs;
  logic serr_line;
  logic [15:0] cmd_m = 16'h0000;
  logic flag_m = 1'b0;
  logic [15:0] c;
  logic [9:0] e_o;
  int bad_count = 0;
  int tests_run = 0;

  pbcmd_host_model i_host (.core_clk(core_clk), .run(run),
    .serr_out(outs[7]), .serr_oe(outs[8]), .evt(evt),
    .serr_line(serr_line));

  pbcmd_primary i_dut (.core_clk(core_clk), .reset(reset),
    .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_addr(cfg_addr),
    .cfg_be(cfg_be), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
    .cfg_rvalid(cfg_rvalid), .reverse_strap(strap[1]),
    .pcix_strap(strap[0]), .pri_io_hit(evt[0]), .pri_mem_hit(evt[1]),
    .fwd_req(evt[2]), .fwd_mwi(evt[3]), .split_cmpl_req(evt[4]),
    .sec_hit(evt[5]), .parity_event(evt[6]), .err_event(evt[7]),
    .intx_req(evt[8]), .pri_io_claim(outs[0]), .pri_mem_claim(outs[1]),
    .pri_master_req(outs[2]), .pri_mwi_cmd(outs[3]),
    .pri_split_req(outs[4]), .sec_claim(outs[5]),
    .err_msg_send(outs[6]), .serr_out(outs[7]), .serr_oe(outs[8]),
    .intx_assert(outs[9]));

  initial
  begin
    forever #50 core_clk = ~core_clk;
  end

  function automatic logic [9:0] exp_out(logic [8:0] e, logic [15:0] m,
    logic [1:0] s);
    logic oe;
    oe = e[7] & m[8] & s[1];
    return {e[8] & ~m[10], oe, ~oe, e[7] & m[8] & ~s[1], e[5] & m[2],
      e[4] & ((s[1] & s[0]) | m[2]), e[2] & e[3] & m[2] & ~s[0],
      e[2] & m[2], e[1] & m[1], e[0] & m[0]};
  endfunction

  function automatic logic [31:0] exp_word();
    return {7'h00, flag_m, 8'h00, cmd_m};
  endfunction

  task automatic chk_out(logic [9:0] exp, logic [9:0] got);
    tests_run++;
    if (got !== exp)
    begin
      bad_count++;
      $display("BAD gated outputs exp %h got %h", exp, got);
    end
  endtask

  task automatic chk_word(string n, logic [31:0] exp, logic [31:0] got);
    tests_run++;
    if (got !== exp)
    begin
      bad_count++;
      $display("BAD %s exp %h got %h", n, exp, got);
    end
  endtask

  task automatic wr(logic [11:0] a, logic [3:0] be, logic [31:0] d);
    @(negedge core_clk);
    cfg_wr = 1'b1;
    cfg_addr = a;
    cfg_be = be;
    cfg_wdata = d;
    @(negedge core_clk);
    cfg_wr = 1'b0;
    if (a == 12'h004)
    begin
      if (be[0])
        cmd_m[7:0] = d[7:0] & RW_BITS[7:0];
      if (be[1])
        cmd_m[15:8] = d[15:8] & RW_BITS[15:8];
      if (be[3] && d[24])
        flag_m = 1'b0;
    end
  endtask

  task automatic rd(string n, logic [11:0] a, logic [31:0] exp);
    @(negedge core_clk);
    cfg_rd = 1'b1;
    cfg_addr = a;
    @(negedge core_clk);
    cfg_rd = 1'b0;
    chk_word(n, exp, cfg_rvalid === 1'b1 ? cfg_rdata : ~exp);
  endtask

  task automatic results();
    $display("Checks %0d, mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // Gated outputs follow last cycle's events under the model command
  always @(negedge core_clk)
  begin
    if (run_q)
    begin
      e_o = exp_out(evt, cmd_m, strap);
      chk_out(e_o & 10'h007, outs & 10'h007);
      chk_out(e_o & 10'h038, outs & 10'h038);
      chk_out(e_o & 10'h3C0, outs & 10'h3C0);
      chk_word("serr line", 32'(!e_o[8]), 32'(serr_line));
      if (evt[6] & cmd_m[6])
        flag_m = 1'b1;
    end
    run_q <= run;
  end

  initial
  begin
    #300000;
    bad_count++;
    results();
  end

  initial
  begin
    void'($urandom(33448));
    repeat (12) @(posedge core_clk);
    @(negedge core_clk);
    reset = 1'b0;
    rd("reset word", 12'h004, 32'h0000_0000);
    wr(12'h004, 4'hF, 32'hFFFF_FFFF);
    rd("all ones", 12'h004, exp_word());
    rd("ones again", 12'h004, exp_word());
    wr(12'h004, 4'h1, 32'h0000_FF00);
    rd("low lane", 12'h004, exp_word());
    wr(12'h004, 4'h2, 32'h0000_00FF);
    rd("high lane", 12'h004, exp_word());
    wr(12'h004, 4'h0, 32'h0000_0000);
    wr(12'h008, 4'hF, 32'h0000_0000);
    rd("no strobe", 12'h004, exp_word());
    rd("unmapped", 12'h008, 32'h0000_0000);
    $display("test register map done");
    for (int i = 0; i < 12; i++)
    begin
      c = (i == 0) ? 16'h0000 : (i == 1) ? 16'hFFFF : 16'($urandom());
      strap = 2'(i);
      wr(12'h004, 4'h3, {16'h0000, c});
      repeat (3) @(negedge core_clk);
      run <= 1'b1;
      repeat (40) @(negedge core_clk);
      run <= 1'b0;
      repeat (2) @(negedge core_clk);
      rd("flag set", 12'h004, exp_word());
      wr(12'h004, 4'h4, 32'hFFFF_FFFF);
      rd("flag held", 12'h004, exp_word());
      wr(12'h004, 4'h8, 32'h0100_0000);
      rd("flag clear", 12'h004, exp_word());
      $display("test traffic %0d done", i);
    end
    results();
  end
endmodule // bridge_primary_command_register_bench
